// ==== core/iqp_pkg.sv ====
// iqp_pkg: constants, types and tables of the i/q playback modulator
// assumes a 200 MHz system clock shared by all users of the package
package iqp_pkg;
   localparam int                SW          = 16;
   localparam int                FRAC        = 14;
   localparam logic [15:0]       Q_ONE       = 16'h4000;
   localparam longint unsigned   CLK_HZ      = 200_000_000;
   localparam int                INIT_TIME_S = 10;
   localparam longint unsigned   INIT_CYC    = longint'(INIT_TIME_S) * CLK_HZ;
   localparam int                FIFO_DEPTH  = 32;
   localparam int                RATE_W      = 40;

   typedef struct packed
   {
      logic signed [SW-1:0] i;
      logic signed [SW-1:0] q;
   } iqp_smp_t;

   typedef struct packed
   {
      logic [3:0]  mod_type;
      logic [15:0] sym_len;
      logic [7:0]  osf;
      logic [1:0]  filt_type;
      logic [7:0]  rolloff;
   } iqp_info_t;

   typedef enum logic [1:0] {TRIG_INT = 2'h0, TRIG_EXT = 2'h1, TRIG_MAN = 2'h2} iqp_trig_t;
   typedef enum logic [1:0] {ST_INIT = 2'h0, ST_IDLE = 2'h1, ST_PLAY = 2'h3} iqp_state_t;

   // gain balance in 1 dB steps, -4 dB .. +3 dB, as Q1.14 linear factors
   localparam logic [15:0] GAIN_LUT [8] = '{16'h2862, 16'h2D4F, 16'h32D6, 16'h390A,
                                            16'h4000, 16'h47CF, 16'h5092, 16'h5A67};
   // one sine period in 16 steps, Q1.14
   localparam logic [15:0] SIN_LUT [16] = '{16'h0000, 16'h187E, 16'h2D41, 16'h3B21,
                                            16'h4000, 16'h3B21, 16'h2D41, 16'h187E,
                                            16'h0000, 16'hE782, 16'hD2BF, 16'hC4DF,
                                            16'hC000, 16'hC4DF, 16'hD2BF, 16'hE782};
endpackage

// ==== core/iqp_top.sv ====
// iqp_top: i/q waveform playback with baseband corrections and if modulator
// assumes waveform and info are loaded through plain ports by a host on clk_sys_i
//
// Notes on behaviour
// [RULE1] after enable, about ten seconds of initialisation pass before any output.
// [RULE2] i stream goes to the in-phase channel, q to the quadrature channel, one setting set.
// [RULE3] carrier zero selects baseband, any other carrier selects if operation.
// [RULE4] in baseband the amplitude scales the complex i/q vector magnitude.
// [RULE5] in if operation only the in-phase channel carries signal, amplitude as its rms.
// [RULE6] sample rate is symbol rate times samples per symbol.
// [RULE7] waveform information is read only and changes only when a waveform is loaded.
// [RULE8] internal trigger repeats the waveform back to back without a pause.
// [RULE9] each external trigger edge plays exactly one waveform cycle.
// [RULE10] each manual trigger request plays exactly one waveform cycle.
// [RULE11] in if operation i and q pass a quadrature modulator without any compensation, then drive ch one.
// [RULE12] imbalance corrections act only in baseband operation.
// [RULE13] a gain balance in decibels sets the level of q against i.
// [RULE14] separate dc offsets are added to i and to q.
// [RULE15] a phase correction is applied to the q channel.
// [RULE16] a cycle is symbol length times oversampling samples; triggered play then stops.
`timescale 1ns/1ps

module iqp_fifo #(
   parameter int W = 32,
   parameter int D = 32
) (
   input  wire logic         clk_sys_i,
   input  wire logic         resetn_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   assign in_ready_o  = (cnt_q != (AW+1)'(D));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rp_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb
   begin
      wp_d  = push ? AW'((wp_q + 1'b1) % D) : wp_q;
      rp_d  = pop ? AW'((rp_q + 1'b1) % D) : rp_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
      if (push)
         mem_q[wp_q] <= in_data_i;
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module iqp_top
   import iqp_pkg::*;
#(
   parameter int          AW          = 10,
   parameter logic [31:0] INIT_CYCLES = 32'(INIT_CYC)
) (
   input  wire logic               clk_sys_i,
   input  wire logic               resetn_i,
   input  wire logic               iq_enable_i,
   input  wire iqp_trig_t          trig_src_i,
   input  wire logic               ext_trig_i,
   input  wire logic               manual_trig_i,
   input  wire logic [31:0]        carrier_fcw_i,
   input  wire logic [15:0]        amplitude_i,
   input  wire logic [31:0]        symbol_rate_i,
   input  wire logic signed [2:0]  gain_bal_db_i,
   input  wire logic signed [15:0] i_offset_i,
   input  wire logic signed [15:0] q_offset_i,
   input  wire logic signed [15:0] q_angle_i,
   input  wire logic               wave_wr_i,
   input  wire logic [AW-1:0]      wave_addr_i,
   input  wire iqp_smp_t           wave_data_i,
   input  wire logic               info_load_i,
   input  wire iqp_info_t          info_i,
   output logic                    init_done_o,
   output logic                    playing_o,
   output logic                    baseband_o,
   output logic [RATE_W-1:0]       sample_rate_o,
   output iqp_info_t               info_o,
   output logic                    sample_stb_o,
   output logic signed [15:0]      in_phase_output_channel_o,
   output logic signed [15:0]      quadrature_output_channel_o
);
   function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
      if (v > 36'sd32767)
         return 16'sh7FFF;
      else if (v < -36'sd32768)
         return 16'sh8000;
      else
         return v[15:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // waveform store, info and rate
   iqp_smp_t          wave_q [2**AW];
   iqp_info_t         info_q, info_d;
   logic [RATE_W-1:0] rate_q, rate_d;
   logic              bb_q, bb_d;

   always_ff @(posedge clk_sys_i)
   begin
      if (wave_wr_i)
         wave_q[wave_addr_i] <= wave_data_i;
   end

   always_comb
   begin
      info_d = info_load_i ? info_i : info_q;                      // [RULE7]
      rate_d = RATE_W'(symbol_rate_i) * RATE_W'(info_q.osf);       // [RULE6]
      bb_d   = (carrier_fcw_i == 32'h0000_0000);                   // [RULE3]
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         info_q <= '0;
         rate_q <= '0;
         bb_q   <= 1'b1;
      end
      else
      begin
         info_q <= info_d;
         rate_q <= rate_d;
         bb_q   <= bb_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger capture
   logic ext_s1_q, ext_s2_q, ext_s3_q, ext_edge;

   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end
      else
      begin
         ext_s1_q <= ext_trig_i;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_edge = ext_s2_q && !ext_s3_q;

   ////////////////////////////////////////////////////////////////////////////
   // init and playback sequencer
   iqp_state_t  st_q, st_d;
   logic [31:0] init_q, init_d;
   logic [23:0] idx_q, idx_d, cyc_len;
   logic        start, last, push, in_ready, f_valid, pop, done_q, done_d;
   iqp_smp_t    f_data;

   assign cyc_len = 24'(info_q.sym_len) * 24'(info_q.osf);         // [RULE16]
   assign push    = (st_q == ST_PLAY) && in_ready;
   assign last    = (idx_q == cyc_len - 24'h000001);

   always_comb
   begin
      st_d   = st_q;
      init_d = init_q;
      idx_d  = idx_q;
      start  = 1'b0;
      case (trig_src_i)
         TRIG_INT: start = 1'b1;                                   // [RULE8]
         TRIG_EXT: start = ext_edge;                               // [RULE9]
         TRIG_MAN: start = manual_trig_i;                          // [RULE10]
         default:  start = 1'b0;
      endcase
      case (st_q)
         ST_INIT:
         begin
            idx_d = '0;
            if (!iq_enable_i)
               init_d = '0;
            else if (init_q == INIT_CYCLES - 32'h1)                // [RULE1]
               st_d = ST_IDLE;
            else
               init_d = init_q + 32'h1;
         end
         ST_IDLE:
         begin
            idx_d = '0;
            if (start && cyc_len != '0)
               st_d = ST_PLAY;
         end
         ST_PLAY:
         begin
            if (push)
            begin
               idx_d = last ? '0 : idx_q + 24'h000001;
               if (last && trig_src_i != TRIG_INT)                 // [RULE16]
                  st_d = ST_IDLE;
            end
         end
         default: st_d = ST_INIT;
      endcase
      if (!iq_enable_i)
      begin
         st_d   = ST_INIT;
         init_d = '0;
      end
      done_d = (st_d != ST_INIT);
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         st_q   <= ST_INIT;
         init_q <= '0;
         idx_q  <= '0;
         done_q <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         init_q <= init_d;
         idx_q  <= idx_d;
         done_q <= done_d;
      end
   end

   iqp_fifo #(.W($bits(iqp_smp_t)), .D(FIFO_DEPTH)) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (st_q == ST_PLAY),
      .in_ready_o  (in_ready),
      .in_data_i   (wave_q[idx_q[AW-1:0]]),
      .out_valid_o (f_valid),
      .out_ready_i (pop),
      .out_data_o  (f_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sample clock, nco and output datapath
   logic [RATE_W:0]    acc_q, acc_d;
   logic               tick;
   logic [31:0]        ph_q, ph_d;
   logic signed [15:0] ch_i_q, ch_i_d, ch_q_q, ch_q_d, cs, sn;
   logic signed [35:0] qg, qa, ia, qs, md;
   logic               stb_q;

   always_comb
   begin
      acc_d = acc_q + {1'b0, rate_q};
      tick  = (acc_d >= (RATE_W+1)'(CLK_HZ));
      if (tick)
         acc_d = acc_d - (RATE_W+1)'(CLK_HZ);
      pop  = tick && f_valid;
      ph_d = pop ? ph_q + carrier_fcw_i : ph_q;
      cs   = SIN_LUT[4'(ph_q[31:28] + 4'h4)];
      sn   = SIN_LUT[ph_q[31:28]];
      // gain balance and phase correction on q
      qg = 36'(f_data.q * $signed({1'b0, GAIN_LUT[3'(gain_bal_db_i + 3'sd4)]})) >>> FRAC;
      qa = qg + (36'(f_data.i * q_angle_i) >>> FRAC);
      // quadrature modulator, real part of one complex multiply by the carrier
      md = (36'(f_data.i * cs) - 36'(f_data.q * sn)) >>> FRAC;
      ch_i_d = ch_i_q;
      ch_q_d = ch_q_q;
      ia     = '0;
      qs     = '0;
      if (pop)
      begin
         if (bb_q)
         begin
            ia = 36'(36'(f_data.i) * $signed({1'b0, amplitude_i})) >>> FRAC; // [RULE4] [RULE2]
            qs = 36'(qa * $signed({1'b0, amplitude_i})) >>> FRAC;    // [RULE13] [RULE15] [RULE12]
            ch_i_d = sat16(ia + 36'(i_offset_i));                     // [RULE14]
            ch_q_d = sat16(qs + 36'(q_offset_i));                     // [RULE14]
         end
         else
         begin
            ia = 36'(md * $signed({1'b0, amplitude_i})) >>> FRAC;    // [RULE11] [RULE5]
            ch_i_d = sat16(ia);
            ch_q_d = '0;                                              // [RULE5]
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         acc_q  <= '0;
         ph_q   <= '0;
         ch_i_q <= '0;
         ch_q_q <= '0;
         stb_q  <= 1'b0;
      end
      else
      begin
         acc_q  <= acc_d;
         ph_q   <= ph_d;
         ch_i_q <= ch_i_d;
         ch_q_q <= ch_q_d;
         stb_q  <= pop;
      end
   end

   assign init_done_o                 = done_q;
   assign playing_o                   = (st_q == ST_PLAY);
   assign baseband_o                  = bb_q;
   assign sample_rate_o               = rate_q;
   assign info_o                      = info_q;
   assign sample_stb_o                = stb_q;
   assign in_phase_output_channel_o   = ch_i_q;
   assign quadrature_output_channel_o = ch_q_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   a_init_wait: assert property ($rose(done_q) |-> $past(init_q) == INIT_CYCLES - 32'h1) // [RULE1]
      else $error("init finished early");
   a_mode_select: assert property (##1 bb_q == ($past(carrier_fcw_i) == 32'h0)) // [RULE3]
      else $error("mode select wrong");
   a_if_q_quiet: assert property (pop && !bb_q |=> ch_q_q == 16'sh0000) // [RULE5]
      else $error("q channel active in if mode");
   a_rate_calc: assert property (##1 rate_q == RATE_W'($past(symbol_rate_i)) * RATE_W'($past(info_q.osf))) // [RULE6]
      else $error("sample rate wrong");
   a_info_hold: assert property (!info_load_i |=> $stable(info_q)) // [RULE7]
      else $error("info changed without load");
   a_int_loop: assert property (push && last && trig_src_i == TRIG_INT && iq_enable_i |=> st_q == ST_PLAY && idx_q == '0) // [RULE8]
      else $error("internal playback paused");
   a_ext_start: assert property (st_q == ST_IDLE && iq_enable_i && trig_src_i == TRIG_EXT && ext_edge && cyc_len != '0 |=> st_q == ST_PLAY) // [RULE9]
      else $error("external edge ignored");
   a_man_start: assert property (st_q == ST_IDLE && iq_enable_i && trig_src_i == TRIG_MAN && !manual_trig_i |=> st_q != ST_PLAY) // [RULE10]
      else $error("manual play without request");
   a_cycle_stop: assert property (push && last && trig_src_i != TRIG_INT |=> st_q != ST_PLAY) // [RULE16]
      else $error("triggered play did not stop");
   a_bb_offset: assert property (pop && bb_q && amplitude_i == 16'h0 |=> ch_i_q == $past(i_offset_i) && ch_q_q == $past(q_offset_i)) // [RULE14]
      else $error("offset not applied");

   c_ext_cycle: cover property (st_q == ST_IDLE && trig_src_i == TRIG_EXT ##1 st_q == ST_PLAY);
   c_int_wrap: cover property (push && last && trig_src_i == TRIG_INT);
   c_if_out: cover property (pop && !bb_q);
endmodule

// ==== verification/iqp_dac_model.sv ====
// iqp_dac_model: dac side of both output channels plus the external trigger source
// assumes sample_stb_i marks a new sample on both channels, one clock domain
`timescale 1ns/1ps

module iqp_dac_model
(
   input  wire logic               clk_sys_i,
   input  wire logic               sample_stb_i,
   input  wire logic signed [15:0] ch1_i,
   input  wire logic signed [15:0] ch2_i,
   output logic                    ext_trig_o
);
   logic signed [15:0] cap_i [64];
   logic signed [15:0] cap_q [64];
   int                 cnt;

   initial
   begin
      ext_trig_o = 1'b0;
      cnt        = 0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // capture one sample pair per strobe
   always @(posedge clk_sys_i)
   begin
      if (sample_stb_i === 1'b1 && cnt < 64)
      begin
         cap_i[cnt] <= ch1_i;
         cap_q[cnt] <= ch2_i;
         cnt        <= cnt + 1;
      end
   end

   task automatic clear();
      cnt = 0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // one cmos pulse, off the clock phase, long enough for the synchroniser
   task automatic pulse_ext();
      #1.3 ext_trig_o = 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1.3 ext_trig_o = 1'b0;
   endtask
endmodule

// ==== verification/iq_playback_modulator_bench.sv ====
// iq_playback_modulator_bench: self-checking bench of the playback modulator
// assumes a short init count and a sample rate of one sample per clock
`timescale 1ns/1ps

module iq_playback_modulator_bench;
   import iqp_pkg::*;
   localparam int NS = 8;
   logic               clk_sys = 1'b0;
   logic               resetn = 1'b0;
   logic               iq_enable = 1'b0;
   iqp_trig_t          trig_src = TRIG_MAN;
   logic               man_trig = 1'b0;
   logic [31:0]        carrier = 32'h0;
   logic signed [15:0] ioff = 16'h0;
   logic signed [15:0] qoff = 16'h0;
   logic signed [15:0] qang = 16'h0;
   logic signed [2:0]  gain = 3'h0;
   logic [15:0]        amp = 16'h4000;
   logic               wr = 1'b0;
   logic [9:0]         addr = 10'h0;
   iqp_smp_t           wdata = '0;
   logic               info_ld = 1'b0;
   iqp_info_t          info = '0;
   logic               ext, init_done, playing, bband, stb;
   logic [RATE_W-1:0]  srate;
   iqp_info_t          info_rd;
   logic signed [15:0] ch1, ch2;
   int                 error_cnt = 0;
   int                 total_checks = 0;

   always #2.5 clk_sys = ~clk_sys;

   iqp_top #(.AW(10), .INIT_CYCLES(32'h10)) iqp_top_i (
      .clk_sys_i(clk_sys), .resetn_i(resetn), .iq_enable_i(iq_enable), .trig_src_i(trig_src),
      .ext_trig_i(ext), .manual_trig_i(man_trig), .carrier_fcw_i(carrier),
      .amplitude_i(amp), .symbol_rate_i(32'd50_000_000), .gain_bal_db_i(gain),
      .i_offset_i(ioff), .q_offset_i(qoff), .q_angle_i(qang), .wave_wr_i(wr),
      .wave_addr_i(addr), .wave_data_i(wdata), .info_load_i(info_ld), .info_i(info),
      .init_done_o(init_done), .playing_o(playing), .baseband_o(bband),
      .sample_rate_o(srate), .info_o(info_rd), .sample_stb_o(stb),
      .in_phase_output_channel_o(ch1), .quadrature_output_channel_o(ch2));

   iqp_dac_model iqp_dac_model_i (
      .clk_sys_i(clk_sys), .sample_stb_i(stb), .ch1_i(ch1), .ch2_i(ch2), .ext_trig_o(ext));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic signed [15:0] wi(input int k);
      return 16'((k + 1) * 256);
   endfunction

   function automatic logic signed [15:0] wq(input int k);
      return 16'(-(k + 1) * 128);
   endfunction

   task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic play(input iqp_trig_t src);
      int n;
      trig_src = src;
      iqp_dac_model_i.clear();
      @(negedge clk_sys);
      if (src == TRIG_MAN)
      begin
         man_trig = 1'b1;
         @(negedge clk_sys);
         man_trig = 1'b0;
      end
      else
         iqp_dac_model_i.pulse_ext();
      n = 0;
      while ((playing !== 1'b0 || iqp_dac_model_i.cnt < NS) && n < 200)
      begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 200)
      begin
         error_cnt++;
         results();
      end
      repeat (20) @(negedge clk_sys);
   endtask

   // mode 0 plain, 1 offsets, 2 phase correction, 3 if operation, 4 gain +1 dB, 5 zero amplitude
   task automatic chk_wave(input string name, input int mode);
      logic signed [15:0] qe;
      logic signed [15:0] ie;
      chk("sample_count", 40'(iqp_dac_model_i.cnt), 40'(NS));
      for (int k = 0; k < NS; k++)
      begin
         qe = (mode == 5) ? qoff : (mode == 1) ? wq(k) + qoff :
              (mode == 2) ? wq(k) + wi(k) / 2 :
              (mode == 4) ? 16'((int'(wq(k)) * int'(GAIN_LUT[5])) >>> FRAC) : wq(k);
         ie = (mode == 5) ? ioff : wi(k) + ioff;
         if (mode == 3)
         begin
            ie = 16'((int'(wi(k)) * int'($signed(SIN_LUT[(k + 4) % 16]))
                      - int'(wq(k)) * int'($signed(SIN_LUT[k % 16]))) >>> FRAC);
            chk("ch1_if", 40'(iqp_dac_model_i.cap_i[k]), 40'(ie));
            chk("ch2_if", 40'(iqp_dac_model_i.cap_q[k]), 40'h0);
         end
         else
         begin
            chk("ch1", 40'(iqp_dac_model_i.cap_i[k]), 40'(ie));
            chk("ch2", 40'(iqp_dac_model_i.cap_q[k]), 40'(qe));
         end
      end
      $display("test %s done", name);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      iq_enable = 1'b1;
      repeat (5) @(negedge clk_sys);
      resetn = 1'b1;
      chk("baseband_after_reset", 40'(bband), 40'h1);
      info = '{mod_type: 4'h3, sym_len: 16'h0002, osf: 8'h04, filt_type: 2'h1, rolloff: 8'h23};
      info_ld = 1'b1;
      @(negedge clk_sys);
      info_ld = 1'b0;
      for (int k = 0; k < NS; k++)
      begin
         wr = 1'b1;
         addr = 10'(k);
         wdata = '{i: wi(k), q: wq(k)};
         @(negedge clk_sys);
      end
      wr = 1'b0;
      chk("info", 40'(info_rd), 40'(info));
      chk("sample_rate", srate, 40'd200_000_000);
      chk("init_early", 40'(init_done), 40'h0);
      repeat (10) @(negedge clk_sys);
      chk("init_done", 40'(init_done), 40'h1);
      $display("test load_init done");
      play(TRIG_MAN);
      chk_wave("manual", 0);
      play(TRIG_EXT);
      chk_wave("external", 0);
      ioff = 16'h0010;
      qoff = 16'hFFE0;
      play(TRIG_MAN);
      chk_wave("offsets", 1);
      ioff = 16'h0;
      qoff = 16'h0;
      qang = 16'h2000;
      play(TRIG_MAN);
      chk_wave("q_angle", 2);
      carrier = 32'h1000_0000;
      qoff = 16'h0100;
      play(TRIG_MAN);
      chk("baseband_if", 40'(bband), 40'h0);
      chk_wave("if_mode", 3);
      carrier = 32'h0;
      qoff = 16'h0;
      qang = 16'h0;
      gain = 3'h1;
      play(TRIG_MAN);
      chk_wave("gain_balance", 4);
      gain = 3'h0;
      amp = 16'h0000;
      ioff = 16'h0010;
      qoff = 16'hFFE0;
      play(TRIG_MAN);
      chk_wave("zero_amplitude", 5);
      amp = 16'h4000;
      ioff = 16'h0;
      qoff = 16'h0;
      trig_src = TRIG_INT;
      repeat (30) @(negedge clk_sys);
      iqp_dac_model_i.clear();
      repeat (24) @(negedge clk_sys);
      chk("internal_count", 40'(iqp_dac_model_i.cnt), 40'd24);
      chk("internal_playing", 40'(playing), 40'h1);
      $display("test internal done");
      results();
   end
endmodule
